// File: logic/tcdt_defines.svh
/*
  timer compare-C, dead-time and interrupt-control constants: offsets, field positions, reset values.
  assumes byte-wide registers addressed by an 8-bit register address.
*/
`ifndef TCDT_DEFINES_SVH
`define TCDT_DEFINES_SVH
`define TCDT_OFS_FLAGS      8'h38
`define TCDT_OFS_MASK       8'h71
`define TCDT_OFS_DT_A       8'h9C
`define TCDT_OFS_DT_B       8'h9D
`define TCDT_OFS_CMPC_LO    8'h9E
`define TCDT_OFS_CMPC_HI    8'h9F
`define TCDT_BIT_OVF        0
`define TCDT_BIT_MA         1
`define TCDT_BIT_MB         2
`define TCDT_BIT_MC         3
`define TCDT_BIT_CAP        5
`define TCDT_MASK_VALID     8'h2F
`define TCDT_FLAG_VALID     8'h2F
`define TCDT_RST_BYTE       8'h00
`define TCDT_RST_WORD       16'h0000
`define TCDT_CNT_MAX        16'hFFFF
`define TCDT_CNT_MIN        16'h0000
`endif

// File: logic/tcdt_pkg.sv
/*
  types for the timer compare-C, dead-time and interrupt-control block.
  assumes tcdt_defines.svh is available on the include path.
*/
package tcdt_pkg;
  typedef enum logic [1:0] {
    TCDT_MODE_NORMAL = 2'b00,
    TCDT_MODE_CTC    = 2'b01,
    TCDT_MODE_PWM    = 2'b10,
    TCDT_MODE_PWM_PC = 2'b11
  } tcdt_mode_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcdt_bus_type;

  typedef struct packed {
    logic overflow;
    logic match_a;
    logic match_b;
    logic match_c;
    logic capture;
  } tcdt_irq_type;

  typedef struct packed {
    logic [15:0] cmpc_active;
    logic [15:0] cmpc_buffer;
    logic [7:0]  cmpc_temp;
    logic [7:0]  dt_a;
    logic [7:0]  dt_b;
    logic [7:0]  mask;
    logic [7:0]  flags;
    logic [7:0]  rdata;
    logic        wave_a_prev;
    logic [7:0]  dt_cnt_a;
    logic [7:0]  dt_cnt_b;
    logic        out_a;
    logic        out_b;
    logic        out_c;
    tcdt_irq_type irq;
  } tcdt_state_type;
endpackage : tcdt_pkg

// File: logic/tcdt_core.sv
/*
  compare-C register pair with pwm double buffering, dead-time generator for the a/b pair,
  interrupt mask and sticky event flags.
  assumes counter, compare-a/b, capture/top, mode and count enable come from the timer core
  on CORE_CLK; software access is a plain byte port with read data one cycle later.
*/
// What this block does
// [R1] compare-C is 16 bits; write high byte first, read low byte first.
// [R2] compare-C is compared with the count on every count cycle.
// [R3] pwm modes double buffer compare-C; normal and clear-on-match write directly.
// [R4] buffered compare-C loads into active only at counter maximum or minimum.
// [R5] software compare-C access goes to buffer when buffered, else active register.
// [R6] with dead time enabled, output A delayed by low dead-time count clocks.
// [R7] with dead time enabled, output B delayed by high dead-time count clocks.
// [R8] mask bit 5 gates capture request with global enable and capture flag.
// [R9] mask bit 3 gates compare-C request with global enable and its flag.
// [R10] mask bit 2 gates compare-B request with global enable and its flag.
// [R11] mask bit 1 gates compare-A request with global enable and its flag.
// [R12] mask bit 0 gates overflow request with global enable and overflow flag.
// [R13] flag bit 5 sets on an input-capture event.
// [R14] flag bit 5 also sets when count reaches capture value used as top.
// [R15] capture flag clears only by software writing one to it.
// [R16] compare-C match sets flag bit 3, kept until software writes one.
// [R17] compare-B match sets flag bit 2, kept until software writes one.
// [R18] compare-A match sets flag bit 1, kept until software writes one.
// [R19] overflow sets flag bit 0, cleared only by software writing one.
// [R20] mask bits 7, 6 and 4 are reserved and read zero.
// [R21] writing zero leaves a flag; set beats a same-cycle clearing write.
`timescale 1ns/1ps
`default_nettype none
`include "tcdt_defines.svh"

module tcdt_core
  import tcdt_pkg::*;
(
  input  wire logic          CORE_CLK,
  input  wire logic          SRST,
  input  wire logic [7:0]    REG_ADDR,
  input  wire logic [7:0]    REG_WDATA,
  input  wire logic          REG_WR,
  input  wire logic          REG_RD,
  output logic      [7:0]    REG_RDATA,
  input  wire logic [15:0]   TIMER_COUNT,
  input  wire logic          COUNT_TICK,
  input  wire logic [15:0]   COMPARE_A_VALUE,
  input  wire logic [15:0]   COMPARE_B_VALUE,
  input  wire logic [15:0]   CAPTURE_VALUE,
  input  wire logic          CAPTURE_IS_TOP,
  input  wire logic          CAPTURE_EVENT,
  input  wire logic          OVERFLOW_EVENT,
  input  wire tcdt_mode_type COUNT_MODE,
  input  wire logic          DEADTIME_ENABLE,
  input  wire logic          WAVE_A_RAW,
  input  wire logic          WAVE_B_RAW,
  input  wire logic          GLOBAL_IRQ_ENABLE,
  output logic               WAVEFORM_OUT_A,
  output logic               WAVEFORM_OUT_B,
  output logic               WAVEFORM_OUT_C,
  output logic               MATCH_C_PULSE,
  output logic [15:0]        COMPARE_C_VALUE,
  output tcdt_irq_type       IRQ_REQUEST
);

  tcdt_state_type st_r;
  tcdt_state_type st_nxt;
  tcdt_bus_type   bus;

  function automatic logic is_pwm(input tcdt_mode_type m);
    is_pwm = (m == TCDT_MODE_PWM) || (m == TCDT_MODE_PWM_PC);
  endfunction : is_pwm

  function automatic logic [7:0] flag_update(input logic [7:0] cur, input logic [7:0] set,
                                             input logic [7:0] clr);
    flag_update = ((cur & ~clr) | set) & `TCDT_FLAG_VALID; // [R21]
  endfunction : flag_update

  function automatic logic [7:0] dt_step(input logic [7:0] cnt, input logic tick);
    dt_step = (tick && cnt != `TCDT_RST_BYTE) ? cnt - 8'h01 : cnt;
  endfunction : dt_step

  logic       buffered;
  logic       hit_a;
  logic       hit_b;
  logic       hit_c;
  logic       at_top;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic       rise_a;
  logic       fall_a;

  always_comb begin
    bus.addr  = REG_ADDR;
    bus.wdata = REG_WDATA;
    bus.wr    = REG_WR;
    bus.rd    = REG_RD;
  end

  always_comb begin
    st_nxt   = st_r;
    buffered = is_pwm(COUNT_MODE); // [R3]
    hit_c    = COUNT_TICK && (TIMER_COUNT == st_r.cmpc_active); // [R2]
    hit_a    = COUNT_TICK && (TIMER_COUNT == COMPARE_A_VALUE);
    hit_b    = COUNT_TICK && (TIMER_COUNT == COMPARE_B_VALUE);
    at_top   = COUNT_TICK && CAPTURE_IS_TOP && (TIMER_COUNT == CAPTURE_VALUE);
    set_v    = `TCDT_RST_BYTE;
    clr_v    = `TCDT_RST_BYTE;
    set_v[`TCDT_BIT_OVF] = OVERFLOW_EVENT; // [R19]
    set_v[`TCDT_BIT_MA]  = hit_a; // [R18]
    set_v[`TCDT_BIT_MB]  = hit_b; // [R17]
    set_v[`TCDT_BIT_MC]  = hit_c; // [R16]
    set_v[`TCDT_BIT_CAP] = CAPTURE_EVENT || at_top; // [R13] [R14]

    // buffered value moves to the active register only at the counter extremes
    if (buffered && COUNT_TICK &&
        (TIMER_COUNT == `TCDT_CNT_MAX || TIMER_COUNT == `TCDT_CNT_MIN)) begin
      st_nxt.cmpc_active = st_r.cmpc_buffer; // [R4]
    end else if (!buffered) begin
      st_nxt.cmpc_buffer = st_r.cmpc_active;
    end

    if (bus.wr) begin
      case (bus.addr)
        `TCDT_OFS_FLAGS:   clr_v = bus.wdata; // [R15]
        `TCDT_OFS_MASK:    st_nxt.mask = bus.wdata & `TCDT_MASK_VALID; // [R20]
        `TCDT_OFS_DT_A:    st_nxt.dt_a = bus.wdata;
        `TCDT_OFS_DT_B:    st_nxt.dt_b = bus.wdata;
        `TCDT_OFS_CMPC_HI: st_nxt.cmpc_temp = bus.wdata; // [R1]
        `TCDT_OFS_CMPC_LO: begin
          if (buffered) begin
            st_nxt.cmpc_buffer = {st_r.cmpc_temp, bus.wdata}; // [R5]
          end else begin
            st_nxt.cmpc_active = {st_r.cmpc_temp, bus.wdata}; // [R3] [R5]
            st_nxt.cmpc_buffer = {st_r.cmpc_temp, bus.wdata};
          end
        end
        default: ;
      endcase
    end
    st_nxt.flags = flag_update(st_r.flags, set_v, clr_v);

    st_nxt.rdata = `TCDT_RST_BYTE;
    if (bus.rd) begin
      case (bus.addr)
        `TCDT_OFS_FLAGS:   st_nxt.rdata = st_r.flags;
        `TCDT_OFS_MASK:    st_nxt.rdata = st_r.mask;
        `TCDT_OFS_DT_A:    st_nxt.rdata = st_r.dt_a;
        `TCDT_OFS_DT_B:    st_nxt.rdata = st_r.dt_b;
        `TCDT_OFS_CMPC_LO: begin
          // low byte read latches the high byte for the following read
          st_nxt.rdata     = buffered ? st_r.cmpc_buffer[7:0] : st_r.cmpc_active[7:0]; // [R1] [R5]
          st_nxt.cmpc_temp = buffered ? st_r.cmpc_buffer[15:8] : st_r.cmpc_active[15:8];
        end
        `TCDT_OFS_CMPC_HI: st_nxt.rdata = st_r.cmpc_temp; // [R1]
        default:           st_nxt.rdata = `TCDT_RST_BYTE;
      endcase
    end

    // dead time: each edge of the a phase starts the delay of the output turning on
    rise_a = WAVE_A_RAW && !st_r.wave_a_prev;
    fall_a = !WAVE_A_RAW && st_r.wave_a_prev;
    st_nxt.wave_a_prev = WAVE_A_RAW;
    st_nxt.dt_cnt_a = rise_a ? st_r.dt_a : dt_step(st_r.dt_cnt_a, COUNT_TICK);
    st_nxt.dt_cnt_b = fall_a ? st_r.dt_b : dt_step(st_r.dt_cnt_b, COUNT_TICK);
    if (DEADTIME_ENABLE) begin
      st_nxt.out_a = WAVE_A_RAW && (st_nxt.dt_cnt_a == `TCDT_RST_BYTE); // [R6]
      st_nxt.out_b = !WAVE_A_RAW && (st_nxt.dt_cnt_b == `TCDT_RST_BYTE); // [R7]
    end else begin
      st_nxt.out_a = WAVE_A_RAW;
      st_nxt.out_b = WAVE_B_RAW;
    end
    if (hit_c) begin
      st_nxt.out_c = !st_r.out_c;
    end

    st_nxt.irq.capture  = GLOBAL_IRQ_ENABLE && st_r.mask[`TCDT_BIT_CAP] && st_r.flags[`TCDT_BIT_CAP]; // [R8]
    st_nxt.irq.match_c  = GLOBAL_IRQ_ENABLE && st_r.mask[`TCDT_BIT_MC] && st_r.flags[`TCDT_BIT_MC]; // [R9]
    st_nxt.irq.match_b  = GLOBAL_IRQ_ENABLE && st_r.mask[`TCDT_BIT_MB] && st_r.flags[`TCDT_BIT_MB]; // [R10]
    st_nxt.irq.match_a  = GLOBAL_IRQ_ENABLE && st_r.mask[`TCDT_BIT_MA] && st_r.flags[`TCDT_BIT_MA]; // [R11]
    st_nxt.irq.overflow = GLOBAL_IRQ_ENABLE && st_r.mask[`TCDT_BIT_OVF] && st_r.flags[`TCDT_BIT_OVF]; // [R12]
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    REG_RDATA       = st_r.rdata;
    WAVEFORM_OUT_A  = st_r.out_a;
    WAVEFORM_OUT_B  = st_r.out_b;
    WAVEFORM_OUT_C  = st_r.out_c;
    COMPARE_C_VALUE = st_r.cmpc_active;
    IRQ_REQUEST     = st_r.irq;
    MATCH_C_PULSE   = COUNT_TICK && (TIMER_COUNT == st_r.cmpc_active);
  end

endmodule : tcdt_core
`default_nettype wire

// File: verif/tcdt_core_props.sv
/* port assertions for tcdt_core.
   assumes a bind into tcdt_core on CORE_CLK. */
`timescale 1ns/1ps
`default_nettype none
module tcdt_core_props
  import tcdt_pkg::*;
(
  input wire logic          CORE_CLK,
  input wire logic          SRST,
  input wire logic          REG_WR,
  input wire logic [15:0]   TIMER_COUNT,
  input wire logic          COUNT_TICK,
  input wire tcdt_mode_type COUNT_MODE,
  input wire logic          GLOBAL_IRQ_ENABLE,
  input wire logic          MATCH_C_PULSE,
  input wire logic          WAVEFORM_OUT_C,
  input wire logic [15:0]   COMPARE_C_VALUE,
  input wire tcdt_irq_type  IRQ_REQUEST
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  sequence s_hold;
    COUNT_MODE[1] && !(COUNT_TICK && (TIMER_COUNT == 16'hFFFF || TIMER_COUNT == 16'h0000));
  endsequence
  sequence s_ovf_seen;
    !REG_WR ##1 (IRQ_REQUEST.overflow && GLOBAL_IRQ_ENABLE && !REG_WR) ##1 (GLOBAL_IRQ_ENABLE && !REG_WR);
  endsequence
  sequence s_cap_seen;
    !REG_WR ##1 (IRQ_REQUEST.capture && GLOBAL_IRQ_ENABLE && !REG_WR) ##1 (GLOBAL_IRQ_ENABLE && !REG_WR);
  endsequence
  property p_match; MATCH_C_PULSE == (COUNT_TICK && TIMER_COUNT == COMPARE_C_VALUE); endproperty
  property p_wave_c; MATCH_C_PULSE |=> (WAVEFORM_OUT_C != $past(WAVEFORM_OUT_C)); endproperty
  property p_wave_c_hold; !MATCH_C_PULSE |=> $stable(WAVEFORM_OUT_C); endproperty
  property p_buf; s_hold |=> $stable(COMPARE_C_VALUE); endproperty
  property p_irq_cap; IRQ_REQUEST.capture |-> $past(GLOBAL_IRQ_ENABLE); endproperty
  property p_irq_mc; IRQ_REQUEST.match_c |-> $past(GLOBAL_IRQ_ENABLE); endproperty
  property p_irq_mb; IRQ_REQUEST.match_b |-> $past(GLOBAL_IRQ_ENABLE); endproperty
  property p_irq_ma; IRQ_REQUEST.match_a |-> $past(GLOBAL_IRQ_ENABLE); endproperty
  property p_irq_ovf; IRQ_REQUEST.overflow |-> $past(GLOBAL_IRQ_ENABLE); endproperty
  property p_ovf_keep; s_ovf_seen |=> IRQ_REQUEST.overflow; endproperty
  property p_cap_keep; s_cap_seen |=> IRQ_REQUEST.capture; endproperty
  a_match: assert property (p_match) else $error("match pulse wrong");
  a_wave_c: assert property (p_wave_c) else $error("output C did not toggle on match");
  a_wave_c_hold: assert property (p_wave_c_hold) else $error("output C moved without match");
  a_buf: assert property (p_buf) else $error("buffered value moved");
  a_irq_cap: assert property (p_irq_cap) else $error("capture request ungated");
  a_irq_mc: assert property (p_irq_mc) else $error("match C request ungated");
  a_irq_mb: assert property (p_irq_mb) else $error("match B request ungated");
  a_irq_ma: assert property (p_irq_ma) else $error("match A request ungated");
  a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request ungated");
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag lost");
  a_cap_keep: assert property (p_cap_keep) else $error("capture flag lost");
endmodule : tcdt_core_props
bind tcdt_core tcdt_core_props u_props (.CORE_CLK, .SRST, .REG_WR, .TIMER_COUNT, .COUNT_TICK, .COUNT_MODE,
  .GLOBAL_IRQ_ENABLE, .MATCH_C_PULSE, .WAVEFORM_OUT_C, .COMPARE_C_VALUE, .IRQ_REQUEST);
`default_nettype wire

// File: verif/testbench.sv
/* self-checking bench for tcdt_core.
   assumes tcdt_pkg and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; $display("mismatch %0t got %h", $time, g); end end
module testbench
  import tcdt_pkg::*;
;
  logic          clk = 0, rst = 1, w_s = 0, r_s = 0, tick = 0, top = 0, cev = 0, oev = 0, dte = 0, wa = 0, gie = 0;
  logic [7:0]    addr = 8'h00, wd = 8'h00, rdat;
  logic [7:0]    mk [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20};
  logic [15:0]   cnt = 16'h0100, ca = 16'h0001, cb = 16'h0002, cap = 16'h0003, cv;
  logic          oa, ob, oc, mcp, wb = 0;
  tcdt_mode_type mode = TCDT_MODE_NORMAL;
  tcdt_irq_type  irq;
  int            bad_count = 0, checks = 0;
  always #10 clk = ~clk;
  tcdt_core DUT (.CORE_CLK(clk), .SRST(rst), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(w_s), .REG_RD(r_s),
    .REG_RDATA(rdat), .TIMER_COUNT(cnt), .COUNT_TICK(tick), .COMPARE_A_VALUE(ca), .COMPARE_B_VALUE(cb),
    .CAPTURE_VALUE(cap), .CAPTURE_IS_TOP(top), .CAPTURE_EVENT(cev), .OVERFLOW_EVENT(oev), .COUNT_MODE(mode),
    .DEADTIME_ENABLE(dte), .WAVE_A_RAW(wa), .WAVE_B_RAW(wb), .GLOBAL_IRQ_ENABLE(gie), .WAVEFORM_OUT_A(oa),
    .WAVEFORM_OUT_B(ob), .WAVEFORM_OUT_C(oc), .MATCH_C_PULSE(mcp), .COMPARE_C_VALUE(cv), .IRQ_REQUEST(irq));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    w_s <= 1'b1;
    @(posedge clk);
    w_s <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    r_s <= 1'b1;
    @(posedge clk);
    r_s <= 1'b0;
    #1 `CHK(rdat, e)
  endtask : rreg
  task automatic tk(input logic [15:0] v, input logic p);
    @(posedge clk);
    cnt <= v;
    tick <= 1'b1;
    #1 `CHK(mcp, p)
    @(posedge clk);
    tick <= 1'b0;
    #1;
  endtask : tk
  task automatic conclude;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  initial begin
    #60000;
    bad_count++;
    conclude();
  end
  initial begin
    cyc(3);
    rst <= 1'b0;
    rreg(8'h38, 8'h00);
    wreg(8'h50, 8'hFF);
    rreg(8'h50, 8'h00);
    wreg(8'h71, 8'hFF);
    rreg(8'h71, 8'h2F);
    wreg(8'h9C, 8'h03);
    rreg(8'h9C, 8'h03);
    wreg(8'h9D, 8'h04);
    rreg(8'h9D, 8'h04);
    wreg(8'h9F, 8'h12);
    #1 `CHK(cv, 16'h0000)
    wreg(8'h9E, 8'h34);
    #1 `CHK(cv, 16'h1234)
    rreg(8'h9E, 8'h34);
    rreg(8'h9F, 8'h12);
    mode <= TCDT_MODE_PWM;
    wreg(8'h9F, 8'h56);
    wreg(8'h9E, 8'h78);
    rreg(8'h9E, 8'h78);
    tk(16'h0100, 1'b0);
    `CHK(cv, 16'h1234)
    tk(16'hFFFF, 1'b0);
    `CHK(cv, 16'h5678)
    mode <= TCDT_MODE_PWM_PC;
    wreg(8'h9F, 8'h9A);
    wreg(8'h9E, 8'hBC);
    #1 `CHK(cv, 16'h5678)
    tk(16'h0000, 1'b0);
    `CHK(cv, 16'h9ABC)
    mode <= TCDT_MODE_CTC;
    wreg(8'h9F, 8'h02);
    wreg(8'h9E, 8'h00);
    ca <= 16'h0200;
    cb <= 16'h0200;
    tk(16'h0200, 1'b1);
    `CHK(oc, 1'b1)
    @(posedge clk);
    oev <= 1'b1;
    cev <= 1'b1;
    @(posedge clk);
    oev <= 1'b0;
    cev <= 1'b0;
    rreg(8'h38, 8'h2F);
    wreg(8'h38, 8'h00);
    rreg(8'h38, 8'h2F);
    gie <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wreg(8'h71, mk[i]);
      cyc(2);
      #1 `CHK(irq, 5'h10 >> i)
    end
    wreg(8'h71, 8'h2F);
    gie <= 1'b0;
    cyc(2);
    #1 `CHK(irq, 5'h00)
    wreg(8'h38, 8'h01);
    rreg(8'h38, 8'h2E);
    wreg(8'h38, 8'h2E);
    rreg(8'h38, 8'h00);
    top <= 1'b1;
    cap <= 16'h0300;
    tk(16'h0300, 1'b0);
    rreg(8'h38, 8'h20);
    @(posedge clk);
    addr <= 8'h38;
    wd <= 8'h20;
    w_s <= 1'b1;
    cev <= 1'b1;
    @(posedge clk);
    w_s <= 1'b0;
    cev <= 1'b0;
    rreg(8'h38, 8'h20);
    cnt <= 16'h0500;
    tick <= 1'b1;
    dte <= 1'b1;
    cyc(8);
    wa <= 1'b1;
    cyc(3);
    #1 `CHK({oa, ob}, 2'h0)
    cyc(1);
    #1 `CHK({oa, ob}, 2'h2)
    wa <= 1'b0;
    cyc(4);
    #1 `CHK({oa, ob}, 2'h0)
    cyc(1);
    #1 `CHK({oa, ob}, 2'h1)
    dte <= 1'b0;
    cyc(2);
    #1 `CHK({oa, ob}, 2'h0)
    wb <= 1'b1;
    cyc(2);
    #1 `CHK({oa, ob}, 2'h1)
    conclude();
  end
endmodule : testbench
`default_nettype wire
